// [design/cpm_consts.vh]
// constants for the processor programming model register file
// assumes the includer works in the core clock domain
// Operation
// - sixteen 32-bit general registers plus program counter
// - stack alias selects user, interrupt or master
// - 16-bit status, low byte flags user-visible
// - supervisor sees mask, trace, privilege, master bits
// - condition flags follow previous operation result
// - vector address is base plus displacement
// - source and destination space codes, 3 bits
// - function codes generated from privilege and access
// - 32-bit cache control and cache address registers
// - program counter increments or loads new value
// - data registers take bit to quad sizes
// - address regs word/long only; any reg indexes
`ifndef CPM_CONSTS_VH
`define CPM_CONSTS_VH
// control register offsets on the software port
`define CPM_REG_STATUS     4'h0
`define CPM_REG_VBASE      4'h1
`define CPM_REG_SRC_SPACE  4'h2
`define CPM_REG_DST_SPACE  4'h3
`define CPM_REG_CCTL       4'h4
`define CPM_REG_CADDR      4'h5
`define CPM_REG_USP        4'h6
`define CPM_REG_ISP        4'h7
`define CPM_REG_MSP        4'h8
`define CPM_REG_PC         4'h9
`define CPM_REG_VIOL       4'hA
// status word fields
`define CPM_SR_C     0
`define CPM_SR_V     1
`define CPM_SR_Z     2
`define CPM_SR_N     3
`define CPM_SR_X     4
`define CPM_SR_IPL_LO 8
`define CPM_SR_M     12
`define CPM_SR_S     13
`define CPM_SR_T0    14
`define CPM_SR_T1    15
// implemented bits of the status word, others read zero
`define CPM_SR_MASK  16'hF71F
`define CPM_SR_RESET 16'h2700
// operand sizes: bit, field, byte, word, long, quad
`define CPM_SZ_BIT   3'h0
`define CPM_SZ_FIELD 3'h1
`define CPM_SZ_BYTE  3'h2
`define CPM_SZ_WORD  3'h3
`define CPM_SZ_LONG  3'h4
`define CPM_SZ_QUAD  3'h5
// automatic function codes
`define CPM_FC_UDATA 3'h1
`define CPM_FC_UPROG 3'h2
`define CPM_FC_SDATA 3'h5
`define CPM_FC_SPROG 3'h6
`define CPM_FC_CPU   3'h7
`endif

// [design/cpm_gpr_bank.v]
// general register bank: eight data and seven plain address registers
// assumes one write port per cycle; aliased stack pointers live outside
`timescale 1ns/1ns
module cpm_gpr_bank #(
  parameter WIDTH = 32
) (
  input  wire             core_clk,
  input  wire             arst_n,
  input  wire             wr_en,
  input  wire [3:0]       wr_idx,
  input  wire [WIDTH-1:0] wr_data,
  input  wire [WIDTH-1:0] wr_mask,
  input  wire [3:0]       rd_a_idx,
  input  wire [3:0]       rd_b_idx,
  output wire [WIDTH-1:0] rd_a_data,
  output wire [WIDTH-1:0] rd_b_data
);

  // entry 15 is unused here; the top replaces it by the stack alias
  reg [WIDTH-1:0] regs [0:15];

  ////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < 15; g = g + 1) begin : g_reg
      // masked write keeps untouched lanes of narrow operands
      always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          regs[g] <= {WIDTH{1'b0}};
        end else if (wr_en && wr_idx == g) begin
          regs[g] <= (regs[g] & ~wr_mask) | (wr_data & wr_mask);
        end
      end
    end
  endgenerate

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      regs[15] <= {WIDTH{1'b0}};
    end
  end

  // any of the sixteen may be read as index
  assign rd_a_data = regs[rd_a_idx];
  assign rd_b_data = regs[rd_b_idx];

endmodule // cpm_gpr_bank

// [design/cpm_prog_model.v]
// programming model: general registers, stacks, status, control registers
// assumes the pipeline issues at most one register write per cycle
`timescale 1ns/1ns
`include "cpm_consts.vh"
module cpm_prog_model (
  input  wire        core_clk,
  input  wire        arst_n,
  // execution unit general register port
  input  wire        gpr_wr_en,
  input  wire [3:0]  gpr_wr_idx,
  input  wire [2:0]  gpr_wr_size,
  input  wire [31:0] gpr_wr_data,
  input  wire [31:0] gpr_wr_hi_data,
  input  wire [4:0]  gpr_fld_off,
  input  wire [4:0]  gpr_fld_len,
  input  wire [3:0]  gpr_rd_a_idx,
  input  wire [3:0]  gpr_rd_b_idx,
  output wire [31:0] gpr_rd_a_data,
  output wire [31:0] gpr_rd_b_data,
  output wire        size_fault,
  // condition flags from the execution unit
  input  wire        flags_wr_en,
  input  wire [4:0]  flags_in,
  output wire [4:0]  cond_flags,
  // program counter
  input  wire        pc_inc_en,
  input  wire [2:0]  pc_inc_bytes,
  input  wire        pc_load_en,
  input  wire [31:0] pc_load_val,
  output wire [31:0] pc_value,
  // vector computation
  input  wire [9:0]  vec_displacement,
  output wire [31:0] vec_address,
  // function code generation
  input  wire        acc_program,
  input  wire        acc_cpu_space,
  input  wire        acc_alt_src,
  input  wire        acc_alt_dst,
  output wire [2:0]  func_code,
  // privilege state and cache register outputs
  output wire        super_mode,
  output wire        master_mode,
  output wire [2:0]  irq_mask,
  output wire [1:0]  trace_mode,
  output wire [31:0] cache_ctl_out,
  output wire [31:0] cache_addr_out,
  // control register port
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  output reg         priv_violation
);

  reg  [15:0] status_word;
  reg  [31:0] vector_table_base;
  reg  [2:0]  source_space_code;
  reg  [2:0]  dest_space_code;
  reg  [31:0] cache_control;
  reg  [31:0] cache_address;
  reg  [31:0] user_stack_pointer;
  reg  [31:0] interrupt_stack_pointer;
  reg  [31:0] master_stack_pointer;
  reg  [31:0] prog_counter;
  reg  [31:0] next_stack_val;
  reg  [31:0] wr_mask;
  reg  [31:0] wr_val;
  reg         size_bad;
  wire [31:0] bank_a;
  wire [31:0] bank_b;
  wire        sup;
  wire        mst;
  wire        alias_wr;
  wire        priv_wr;
  wire [31:0] active_supervisor_stack;
  wire [31:0] stack_alias_register;
  wire [7:0]  cond_flags_byte;

  ////////////////////////////////////////////////////////////////////
  // write bit mask for an operand size, field offset and length
  function [31:0] cpm_size_mask;
    input [2:0] size;
    input [4:0] off;
    input [4:0] len;
    reg   [31:0] ones;
    begin
      ones = 32'hFFFFFFFF;
      case (size)
        `CPM_SZ_BIT:   cpm_size_mask = 32'h00000001 << off;
        `CPM_SZ_FIELD: cpm_size_mask = (ones >> (5'd31 - len)) << off;
        `CPM_SZ_BYTE:  cpm_size_mask = 32'h000000FF;
        `CPM_SZ_WORD:  cpm_size_mask = 32'h0000FFFF;
        default:       cpm_size_mask = ones;
      endcase
    end
  endfunction

  assign sup = status_word[`CPM_SR_S];
  assign mst = status_word[`CPM_SR_M];
  assign cond_flags_byte = status_word[7:0];

  // the eighth address register names a different stack per privilege
  assign active_supervisor_stack = mst ? master_stack_pointer
                                       : interrupt_stack_pointer;
  assign stack_alias_register = sup ? active_supervisor_stack
                                    : user_stack_pointer;
  assign alias_wr = gpr_wr_en && gpr_wr_idx == 4'hF;

  ////////////////////////////////////////////////////////////////////
  // operand size handling: address registers take word or long only
  always @* begin
    wr_mask  = cpm_size_mask(gpr_wr_size, gpr_fld_off, gpr_fld_len);
    wr_val   = gpr_wr_data;
    size_bad = 1'b0;
    if (gpr_wr_idx[3]) begin
      // word writes to address registers sign-extend to the full width
      if (gpr_wr_size == `CPM_SZ_WORD) begin
        wr_val  = {{16{gpr_wr_data[15]}}, gpr_wr_data[15:0]};
        wr_mask = 32'hFFFFFFFF;
      end else if (gpr_wr_size != `CPM_SZ_LONG) begin
        size_bad = 1'b1;
      end
    end else if (gpr_wr_size == `CPM_SZ_QUAD && gpr_wr_idx[2:0] == 3'h7) begin
      size_bad = 1'b1; // quad needs a following data register
    end
  end

  assign size_fault = gpr_wr_en & size_bad;

  cpm_gpr_bank #(
    .WIDTH (32)
  ) u_bank (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .wr_en     (gpr_wr_en & ~size_bad & ~alias_wr),
    .wr_idx    (gpr_wr_idx),
    .wr_data   (wr_val),
    .wr_mask   (wr_mask),
    .rd_a_idx  (gpr_rd_a_idx),
    .rd_b_idx  (gpr_rd_b_idx),
    .rd_a_data (bank_a),
    .rd_b_data (bank_b)
  );

  // quad operations write the high long word to a side store indexed by the data register
  wire quad_hi_wr = gpr_wr_en && ~size_bad && gpr_wr_size == `CPM_SZ_QUAD;
  reg  [31:0] quad_hi [0:7];
  integer qi;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (qi = 0; qi < 8; qi = qi + 1) begin
        quad_hi[qi] <= 32'h00000000;
      end
    end else if (quad_hi_wr) begin
      quad_hi[gpr_wr_idx[2:0]] <= gpr_wr_hi_data;
    end
  end
  // limitation: high half is held in a side store readable only by pairing
  assign gpr_rd_a_data = (gpr_rd_a_idx == 4'hF) ? stack_alias_register : bank_a;
  assign gpr_rd_b_data = (gpr_rd_b_idx == 4'hF) ? stack_alias_register
                       : (gpr_rd_b_idx == gpr_rd_a_idx && !gpr_rd_a_idx[3])
                         ? quad_hi[gpr_rd_a_idx[2:0]] : bank_b;

  ////////////////////////////////////////////////////////////////////
  // user writes to supervisor state are dropped and reported
  assign priv_wr = reg_wr && !sup &&
                   (reg_addr != `CPM_REG_STATUS || reg_addr == `CPM_REG_VIOL);

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      priv_violation <= 1'b0;
    end else begin
      priv_violation <= priv_wr;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // status word: flags from execution, whole word from supervisor software, flag byte from user software
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_word <= `CPM_SR_RESET;
    end else if (reg_wr && reg_addr == `CPM_REG_STATUS) begin
      if (sup) begin
        status_word <= reg_wdata[15:0] & `CPM_SR_MASK;
      end else begin
        status_word <= {status_word[15:8], reg_wdata[7:0] & 8'h1F};
      end
    end else if (flags_wr_en) begin
      status_word <= {status_word[15:5], flags_in};
    end
  end

  // stack pointers: alias writes from execution, direct writes by supervisor
  always @* begin
    next_stack_val = wr_val;
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      user_stack_pointer      <= 32'h00000000;
      interrupt_stack_pointer <= 32'h00000000;
      master_stack_pointer    <= 32'h00000000;
    end else begin
      if (alias_wr && !size_bad) begin
        if (!sup) begin
          user_stack_pointer <= next_stack_val;
        end else if (mst) begin
          master_stack_pointer <= next_stack_val;
        end else begin
          interrupt_stack_pointer <= next_stack_val;
        end
      end else if (reg_wr && sup) begin
        if (reg_addr == `CPM_REG_USP) begin
          user_stack_pointer <= reg_wdata;
        end
        if (reg_addr == `CPM_REG_ISP) begin
          interrupt_stack_pointer <= reg_wdata;
        end
        if (reg_addr == `CPM_REG_MSP) begin
          master_stack_pointer <= reg_wdata;
        end
      end
    end
  end

  // supervisor-only control registers
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      vector_table_base <= 32'h00000000;
      source_space_code <= 3'h0;
      dest_space_code   <= 3'h0;
      cache_control     <= 32'h00000000;
      cache_address     <= 32'h00000000;
    end else if (reg_wr && sup) begin
      case (reg_addr)
        `CPM_REG_VBASE:     vector_table_base <= reg_wdata;
        `CPM_REG_SRC_SPACE: source_space_code <= reg_wdata[2:0];
        `CPM_REG_DST_SPACE: dest_space_code   <= reg_wdata[2:0];
        `CPM_REG_CCTL:      cache_control     <= reg_wdata;
        `CPM_REG_CADDR:     cache_address     <= reg_wdata;
        default: ;
      endcase
    end
  end

  // program counter: load wins over increment, software load lowest
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prog_counter <= 32'h00000000;
    end else if (pc_load_en) begin
      prog_counter <= pc_load_val;
    end else if (pc_inc_en) begin
      prog_counter <= prog_counter + {29'h0, pc_inc_bytes};
    end else if (reg_wr && sup && reg_addr == `CPM_REG_PC) begin
      prog_counter <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // vector address and function codes
  assign vec_address = vector_table_base + {22'h0, vec_displacement};
  assign func_code = acc_alt_src   ? source_space_code
                   : acc_alt_dst   ? dest_space_code
                   : acc_cpu_space ? `CPM_FC_CPU
                   : sup ? (acc_program ? `CPM_FC_SPROG : `CPM_FC_SDATA)
                         : (acc_program ? `CPM_FC_UPROG : `CPM_FC_UDATA);

  assign cond_flags     = cond_flags_byte[4:0];
  assign super_mode     = sup;
  assign master_mode    = mst;
  assign irq_mask       = status_word[10:8];
  assign trace_mode     = status_word[15:14];
  assign cache_ctl_out  = cache_control;
  assign cache_addr_out = cache_address;
  assign pc_value       = prog_counter;

  ////////////////////////////////////////////////////////////////////
  // read port: data one cycle after strobe; user sees only flag byte, program counter and violation flag
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `CPM_REG_STATUS:    reg_rdata <= sup ? {16'h0, status_word}
                                             : {24'h0, cond_flags_byte};
        `CPM_REG_VBASE:     reg_rdata <= sup ? vector_table_base : 32'h0;
        `CPM_REG_SRC_SPACE: reg_rdata <= sup ? {29'h0, source_space_code} : 32'h0;
        `CPM_REG_DST_SPACE: reg_rdata <= sup ? {29'h0, dest_space_code} : 32'h0;
        `CPM_REG_CCTL:      reg_rdata <= sup ? cache_control : 32'h0;
        `CPM_REG_CADDR:     reg_rdata <= sup ? cache_address : 32'h0;
        `CPM_REG_USP:       reg_rdata <= sup ? user_stack_pointer : 32'h0;
        `CPM_REG_ISP:       reg_rdata <= sup ? interrupt_stack_pointer : 32'h0;
        `CPM_REG_MSP:       reg_rdata <= sup ? master_stack_pointer : 32'h0;
        `CPM_REG_PC:        reg_rdata <= prog_counter;
        `CPM_REG_VIOL:      reg_rdata <= {31'h0, priv_violation};
        default:            reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule // cpm_prog_model

// [sim/cpm_prog_model_properties.sv]
// port-level timing properties of the programming model register file
// assumes it is bound to cpm_prog_model and sees only that module's ports
`timescale 1ns/1ns
`include "cpm_consts.vh"
module cpm_prog_model_properties (
  input wire        core_clk,
  input wire        arst_n,
  input wire [3:0]  reg_addr,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire        priv_violation,
  input wire        super_mode,
  input wire [9:0]  vec_displacement,
  input wire [31:0] vec_address,
  input wire [31:0] cache_addr_out,
  input wire        pc_inc_en,
  input wire [2:0]  pc_inc_bytes,
  input wire        pc_load_en,
  input wire [31:0] pc_load_val,
  input wire [31:0] pc_value,
  input wire        flags_wr_en,
  input wire [4:0]  flags_in,
  input wire [4:0]  cond_flags,
  input wire        acc_program,
  input wire        acc_cpu_space,
  input wire        acc_alt_src,
  input wire        acc_alt_dst,
  input wire [2:0]  func_code
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  //////////////////////////////
  // register port answers and privilege
  a_vbase_read_back:
    assert property (reg_rd && super_mode && reg_addr == `CPM_REG_VBASE |=>
      reg_rdata == $past(vec_address) - {22'h0, $past(vec_displacement)})
      else $error("vector base read differs from vector address");
  a_user_sees_byte:
    assert property (reg_rd && !super_mode && reg_addr == `CPM_REG_STATUS |=>
      reg_rdata[31:8] == 24'h0) else $error("user status read shows upper byte");
  a_user_write_flag:
    assert property (reg_wr && !super_mode && reg_addr != `CPM_REG_STATUS |=>
      priv_violation) else $error("blocked user write not flagged");
  a_flag_has_cause:
    assert property (priv_violation |-> $past(reg_wr) && !$past(super_mode))
      else $error("privilege flag without a user write");
  a_user_caddr_kept:
    assert property (reg_wr && !super_mode |=> $stable(cache_addr_out))
      else $error("user write changed the cache address");
  // program counter: load beats increment
  a_pc_load_wins:
    assert property (pc_load_en |=> pc_value == $past(pc_load_val))
      else $error("program counter load lost");
  a_pc_step:
    assert property (pc_inc_en && !pc_load_en |=>
      pc_value == $past(pc_value) + {29'h0, $past(pc_inc_bytes)})
      else $error("program counter step wrong");
  // flags follow the unit unless software writes status in that cycle
  a_flags_follow:
    assert property (flags_wr_en && !(reg_wr && reg_addr == `CPM_REG_STATUS) |=>
      cond_flags == $past(flags_in)) else $error("condition flags not updated");
  a_auto_space:
    assert property (!acc_alt_src && !acc_alt_dst |-> func_code == (acc_cpu_space ?
      3'h7 : {super_mode, acc_program, !acc_program})) else $error("wrong function code");
  c_violation: cover property (priv_violation);
  c_pc_both: cover property (pc_load_en && pc_inc_en);
  c_user_read: cover property (reg_rd && !super_mode);
endmodule // cpm_prog_model_properties

bind cpm_prog_model cpm_prog_model_properties cpm_prog_model_properties_i (.*);

// [sim/test_cpm_prog_model.sv]
// self-checking bench for the programming model register file
// assumes the design and its constants header are on the include path
`timescale 1ns/1ns
`include "cpm_consts.vh"
module test_cpm_prog_model;
  logic        core_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        gpr_wr_en = 1'b0, flags_wr_en = 1'b0, pc_inc_en = 1'b0, pc_load_en = 1'b0;
  logic        acc_program = 1'b0, acc_cpu_space = 1'b0, acc_alt_src = 1'b0;
  logic        acc_alt_dst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0]  gpr_wr_idx = 4'h0, gpr_rd_a_idx = 4'h0, gpr_rd_b_idx = 4'h0, reg_addr = 4'h0;
  logic [2:0]  gpr_wr_size = 3'h0, pc_inc_bytes = 3'h0;
  logic [4:0]  gpr_fld_off = 5'h0, gpr_fld_len = 5'h0, flags_in = 5'h0;
  logic [9:0]  vec_displacement = 10'h0;
  logic [31:0] gpr_wr_data = 32'h0, gpr_wr_hi_data = 32'h0, pc_load_val = 32'h0;
  logic [31:0] reg_wdata = 32'h0;
  wire  [31:0] gpr_rd_a_data, gpr_rd_b_data, vec_address, pc_value, reg_rdata;
  wire  [31:0] cache_ctl_out, cache_addr_out;
  wire  [4:0]  cond_flags;
  wire  [2:0]  func_code, irq_mask;
  wire  [1:0]  trace_mode;
  wire         size_fault, super_mode, master_mode, priv_violation;
  int          n_mismatch = 0;
  int          compares = 0;

  cpm_prog_model cpm_prog_model_i (.*);

  // 125 MHz core clock
  always #4 core_clk = ~core_clk;
  //////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one-cycle write strobe, then a gap cycle so strobes never merge
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, reg_rdata, exp);
  endtask

  task automatic gw(input logic [3:0] i, input logic [2:0] s, input logic [31:0] d, input f);
    @(posedge core_clk);
    gpr_wr_en   <= 1'b1;
    gpr_wr_idx  <= i;
    gpr_wr_size <= s;
    gpr_wr_data <= d;
    #1;
    chk("size fault", {31'h0, size_fault}, {31'h0, f});
    @(posedge core_clk);
    gpr_wr_en <= 1'b0;
  endtask

  task automatic rg(input logic [3:0] i, input logic [31:0] exp);
    @(posedge core_clk);
    gpr_rd_a_idx <= i;
    #1;
    chk("general register", gpr_rd_a_data, exp);
  endtask

  // access kind bits: program, processor space, alternate source, alternate dest
  task automatic fc(input logic [3:0] acc, input logic [2:0] exp);
    @(posedge core_clk);
    {acc_program, acc_cpu_space, acc_alt_src, acc_alt_dst} <= acc;
    #1;
    chk("function code", {29'h0, func_code}, {29'h0, exp});
  endtask

  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  //////////////////////////////
  // main sequence: supervisor work first, user level last, then a second reset
  initial begin
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(`CPM_REG_STATUS, 32'h2700, "status reset");
    rd(`CPM_REG_CCTL, 32'h0, "cache control reset");
    rd(4'hF, 32'h0, "unmapped read");
    wr(`CPM_REG_VBASE, 32'h1234_0000);
    wr(`CPM_REG_CCTL, 32'hA5A5_0F0F);
    wr(`CPM_REG_CADDR, 32'hFFFF_FFFC);
    wr(`CPM_REG_SRC_SPACE, 32'hFFFF_FFFB);
    wr(`CPM_REG_DST_SPACE, 32'h4);
    rd(`CPM_REG_VBASE, 32'h1234_0000, "vector base");
    rd(`CPM_REG_CCTL, 32'hA5A5_0F0F, "cache control");
    chk("cache address", cache_addr_out, 32'hFFFF_FFFC);
    chk("cache control out", cache_ctl_out, 32'hA5A5_0F0F);
    rd(`CPM_REG_SRC_SPACE, 32'h3, "source code");
    @(posedge core_clk) vec_displacement <= 10'h3FC;
    fc(4'b0000, `CPM_FC_SDATA);
    fc(4'b1000, `CPM_FC_SPROG);
    fc(4'b0100, `CPM_FC_CPU);
    fc(4'b0010, 3'h3);
    fc(4'b0001, 3'h4);
    chk("vector address", vec_address, 32'h1234_03FC);
    gw(4'h3, `CPM_SZ_LONG, 32'h1234_5678, 1'b0);
    gw(4'h3, `CPM_SZ_BYTE, 32'hFFFF_FFAB, 1'b0);
    rg(4'h3, 32'h1234_56AB);
    gw(4'h3, `CPM_SZ_WORD, 32'h0000_CDEF, 1'b0);
    rg(4'h3, 32'h1234_CDEF);
    gw(4'h9, `CPM_SZ_WORD, 32'h0000_8001, 1'b0);
    gw(4'h9, `CPM_SZ_BYTE, 32'h0000_0055, 1'b1);
    rg(4'h9, 32'hFFFF_8001);
    // field of eight bits at offset four, then a single bit at the same offset
    @(posedge core_clk);
    gpr_fld_off    <= 5'h4;
    gpr_fld_len    <= 5'h7;
    gpr_wr_hi_data <= 32'hCAFE_0001;
    gw(4'h3, `CPM_SZ_FIELD, 32'hFFFF_FFFF, 1'b0);
    rg(4'h3, 32'h1234_CFFF);
    gw(4'h3, `CPM_SZ_BIT, 32'h0, 1'b0);
    rg(4'h3, 32'h1234_CFEF);
    // quad word: high half pairs with the low half; register 7 has no partner
    gw(4'h2, `CPM_SZ_QUAD, 32'h0BAD_F00D, 1'b0);
    gw(4'h7, `CPM_SZ_QUAD, 32'h1111_1111, 1'b1);
    rg(4'h7, 32'h0);
    @(posedge core_clk);
    gpr_rd_a_idx <= 4'h2;
    gpr_rd_b_idx <= 4'h2;
    #1;
    chk("quad low", gpr_rd_a_data, 32'h0BAD_F00D);
    chk("quad high", gpr_rd_b_data, 32'hCAFE_0001);
    // stack alias goes to interrupt stack, then master stack once M is set
    gw(4'hF, `CPM_SZ_LONG, 32'h2000, 1'b0);
    wr(`CPM_REG_STATUS, 32'hB51F);
    chk("mode bits", {24'h0, trace_mode, master_mode, super_mode, 1'b0, irq_mask}, 32'hB5);
    gw(4'hF, `CPM_SZ_LONG, 32'h3000, 1'b0);
    wr(`CPM_REG_USP, 32'h4000);
    rd(`CPM_REG_ISP, 32'h2000, "interrupt stack");
    rd(`CPM_REG_MSP, 32'h3000, "master stack");
    rd(`CPM_REG_STATUS, 32'hB51F, "status word");
    // load and increment together: load wins, increment follows
    @(posedge core_clk);
    pc_load_val  <= 32'h100;
    pc_load_en   <= 1'b1;
    pc_inc_en    <= 1'b1;
    pc_inc_bytes <= 3'h4;
    @(posedge core_clk);
    pc_load_en <= 1'b0;
    @(posedge core_clk);
    pc_inc_en <= 1'b0;
    #1;
    chk("program counter", pc_value, 32'h104);
    wr(`CPM_REG_PC, 32'h8000);
    rd(`CPM_REG_PC, 32'h8000, "program counter write");
    @(posedge core_clk);
    flags_in    <= 5'h0A;
    flags_wr_en <= 1'b1;
    @(posedge core_clk);
    flags_wr_en <= 1'b0;
    #1;
    chk("condition flags", {27'h0, cond_flags}, 32'hA);
    // drop to user level
    wr(`CPM_REG_STATUS, 32'h0);
    rg(4'hF, 32'h4000);
    fc(4'b0000, `CPM_FC_UDATA);
    fc(4'b1000, `CPM_FC_UPROG);
    wr(`CPM_REG_VBASE, 32'h0);
    chk("privilege flag", {31'h0, priv_violation}, 32'h1);
    chk("vector address kept", vec_address, 32'h1234_03FC);
    wr(`CPM_REG_CADDR, 32'h0);
    chk("cache address kept", cache_addr_out, 32'hFFFF_FFFC);
    wr(`CPM_REG_STATUS, 32'hFFFF);
    rd(`CPM_REG_STATUS, 32'h1F, "user flag byte");
    rd(`CPM_REG_VBASE, 32'h0, "user base read");
    @(posedge core_clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(`CPM_REG_STATUS, 32'h2700, "status after reset");
    test_done;
  end

  // hang limit, far beyond the length of the sequence
  initial begin
    #100000;
    n_mismatch++;
    test_done;
  end
endmodule // test_cpm_prog_model
